/* hw/retloop_consts.svh */
`ifndef RETLOOP_CONSTS_SVH
`define RETLOOP_CONSTS_SVH

// Register offsets on the plain register port.
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4

// Field positions.
`define CTRL_DUAL_BIT 0
`define STATUS_ACTIVE_BIT 16
`define STATUS_SUPPRESS_BIT 17
`define RET_X_BIT 2
`define RET_J_BIT 1
`define RET_LR_BIT 0

// Termination and condition codes.
`define TERM_LCE 5'h0F
`define TERM_FOREVER 5'h1F
`define TERM_NEG_BIT 4

// Reset values.
`define CTRL_RESET 1'h0
`define COUNT_RESET 16'h0000

// Address of the first loop instruction relative to the setup instruction.
`define LOOP_START_STEP 24'h000001

`endif

/* hw/retloop_pkg.sv */
package retloop_pkg;

    typedef logic [23:0] pc_t;
    typedef logic [15:0] cnt_t;

    // Instruction classes handled by this decoder.
    typedef enum logic [2:0] {
        KIND_NONE = 3'h0,
        KIND_RET = 3'h1,
        KIND_LOOP_IMM = 3'h2,
        KIND_LOOP_UREG = 3'h3,
        KIND_LOOP_COND = 3'h4
    } instr_kind_e;

    // Decoded instruction fields.
    typedef struct packed {
        instr_kind_e kind;
        logic [2:0] ret_field;
        logic has_compute;
        logic else_compute;
        logic [4:0] cond;
        logic loop_f_mode;
        logic addr_relative;
        pc_t addr;
        cnt_t imm16;
        logic [3:0] ureg_sel;
    } instr_s;

    // Arithmetic status of one processing element.
    typedef struct packed {
        logic eq;
        logic lt;
        logic le;
        logic ac;
        logic av;
        logic mv;
        logic ms;
        logic sv;
        logic sz;
        logic tf;
        logic bit_test;
    } pe_status_s;

    // Entry pushed onto the loop address stack.
    typedef struct packed {
        pc_t end_addr;
        logic [4:0] term;
        logic f_active;
    } loop_entry_s;

endpackage

/* hw/cond_eval.sv */
`timescale 1ns/10ps
`include "retloop_consts.svh"

// Evaluates one five-bit condition code against one element's status.
module cond_eval
    import retloop_pkg::*;
(
    input wire logic [4:0] code,
    input pe_status_s status,
    input wire logic [3:0] flags,
    input wire logic lce,
    output logic result
);

    logic [15:0] tests;
    logic base;

    // Low codes are true tests; the top bit inverts them.
    assign tests = {lce, status.bit_test, status.tf, flags[3], flags[2], flags[1], flags[0],
                    status.sz, status.sv, status.ms, status.mv, status.av, status.ac,
                    status.le, status.lt, status.eq};
    assign base = tests[code[3:0]];
    assign result = code[`TERM_NEG_BIT] ? ~base : base;

endmodule

/* hw/retloop_decode.sv */
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "retloop_consts.svh"

// Behaviour
// - Dual mode returns only when condition holds in both elements.
// - Dual mode, second element computes on the complementary register set.
// - Else-compute runs per element, only where the condition is false.
// - Single mode unconditional interrupt return runs return and compute together.
// - Single mode conditional return branches when true; else-compute runs when false.
// - Dual mode, first result to primary register, second to secondary file.
// - Return field is x, j, lr; interrupt return forces lr clear.
// - Counter loop loads count from 16-bit immediate or a universal register.
// - Every loop setup pushes the first loop instruction address on PC stack.
// - Counter loop pushes end address with count-expired condition on loop stack.
// - End address is absolute 24-bit or 24-bit offset from current PC.
// - Count is pushed and becomes current count; loop ends when it hits zero.
// - Instruction bit 23 picks E2-stage (0) or F1-stage (1) loop activation.
// - Conditional loop pushes end and condition; single mode ends when true.
// - Dual mode conditional loop ends only when true in both elements.
// - Five-bit code: low half true tests, high half negations, 11111 forever.
// - Interrupt return clears serviced bit in latch and mask pointer.
// - Subroutine return with loop reentry blocks a second count decrement.
// - Delayed-branch option makes the return delayed, otherwise non-delayed.
module retloop_decode
    import retloop_pkg::*;
#(
    parameter int IRQ_W = 32,
    parameter int IDX_W = 5
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic instr_valid,
    input instr_s instr,
    input pe_status_s status_x,
    input pe_status_s status_y,
    input wire logic [3:0] flag_in,
    input pc_t pc,
    input wire logic [31:0] ureg_data,
    input wire logic [IDX_W-1:0] irq_index,
    input wire logic loop_dec_tick,
    input wire logic loop_exit,
    output logic ret_take,
    output logic ret_interrupt,
    output logic delayed_branch_option,
    output logic loop_reentry_option,
    output logic compute_x,
    output logic compute_y,
    output logic compute_y_complement,
    output logic pc_push,
    output pc_t pc_push_data,
    output logic loop_push,
    output loop_entry_s loop_push_data,
    output logic count_push,
    output cnt_t count_push_data,
    output logic [IRQ_W-1:0] latch_clear_mask,
    output logic [IRQ_W-1:0] mask_ptr_clear_mask,
    output cnt_t current_loop_count,
    output logic loop_active,
    output logic loop_done
);

    // Control and state registers.
    logic dual_element_mode;
    logic suppress_dec;
    logic [4:0] active_term;
    logic [3:0] flag_meta;
    logic [3:0] flag_sync;

    // Flag pins come from outside the clock domain and pass two flops.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_meta <= 4'h0;
            flag_sync <= 4'h0;
        end else begin
            flag_meta <= flag_in;
            flag_sync <= flag_meta;
        end
    end

    // Register port decode.
    logic wr_ctrl;
    logic rd_ctrl;
    logic rd_status;
    logic [31:0] status_word;
    logic [31:0] next_rdata;

    assign wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
    assign rd_ctrl = reg_rd && (reg_addr == `ADDR_CTRL);
    assign rd_status = reg_rd && (reg_addr == `ADDR_STATUS);
    assign status_word = {14'h0000, suppress_dec, loop_active, current_loop_count};
    assign next_rdata = rd_ctrl ? {31'h00000000, dual_element_mode} :
                        rd_status ? status_word : 32'h00000000;

    // Control write and read data, which stands only the cycle after the read.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dual_element_mode <= `CTRL_RESET;
            reg_rdata <= 32'h00000000;
        end else begin
            if (wr_ctrl) begin
                dual_element_mode <= reg_wdata[`CTRL_DUAL_BIT];
            end
            reg_rdata <= next_rdata;
        end
    end

    // Count-expired test seen by the condition logic.
    logic lce;

    assign lce = (current_loop_count == `COUNT_RESET);

    // Return condition, evaluated in each element.
    logic ret_raw_x;
    logic ret_raw_y;
    logic ret_uncond;
    logic cond_x;
    logic cond_y;

    cond_eval u_ret_x (
        .code(instr.cond),
        .status(status_x),
        .flags(flag_sync),
        .lce(lce),
        .result(ret_raw_x)
    );

    cond_eval u_ret_y (
        .code(instr.cond),
        .status(status_y),
        .flags(flag_sync),
        .lce(lce),
        .result(ret_raw_y)
    );

    // Code 11111 on a return means no condition at all.
    assign ret_uncond = (instr.cond == `TERM_FOREVER);
    assign cond_x = ret_uncond || ret_raw_x;
    assign cond_y = ret_uncond || ret_raw_y;

    // Return decode.
    logic is_ret;
    logic ret_x_bit;
    logic ret_j_bit;
    logic ret_lr_bit;
    logic ret_go;
    logic next_comp_x;
    logic next_comp_y;

    assign is_ret = instr_valid && (instr.kind == KIND_RET);
    assign ret_x_bit = instr.ret_field[`RET_X_BIT];
    assign ret_j_bit = instr.ret_field[`RET_J_BIT];
    assign ret_lr_bit = ~ret_x_bit & instr.ret_field[`RET_LR_BIT];
    // Dual mode needs both elements; single mode looks at the first only.
    assign ret_go = is_ret && (dual_element_mode ? (cond_x && cond_y) : cond_x);
    // Plain compute runs beside the return; else-compute only where false.
    assign next_comp_x = is_ret && instr.has_compute &&
                         (instr.else_compute ? ~cond_x : cond_x);
    assign next_comp_y = is_ret && instr.has_compute && dual_element_mode &&
                         (instr.else_compute ? ~cond_y : cond_y);

    // Interrupt clear mask for the serviced interrupt.
    logic ret_irq;
    logic [IRQ_W-1:0] irq_onehot;

    assign ret_irq = ret_go && ret_x_bit;
    assign irq_onehot = {{(IRQ_W-1){1'b0}}, 1'b1} << irq_index;

    // Return outputs, registered one cycle after the instruction.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ret_take <= 1'b0;
            ret_interrupt <= 1'b0;
            delayed_branch_option <= 1'b0;
            loop_reentry_option <= 1'b0;
            compute_x <= 1'b0;
            compute_y <= 1'b0;
            compute_y_complement <= 1'b0;
        end else begin
            ret_take <= ret_go;
            ret_interrupt <= ret_irq;
            delayed_branch_option <= ret_go && ret_j_bit;
            loop_reentry_option <= ret_go && ret_lr_bit;
            compute_x <= next_comp_x;
            compute_y <= next_comp_y;
            compute_y_complement <= next_comp_y;
        end
    end

    // Serviced interrupt bit is cleared in the latch and the mask pointer.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch_clear_mask <= '0;
            mask_ptr_clear_mask <= '0;
        end else begin
            latch_clear_mask <= ret_irq ? irq_onehot : '0;
            mask_ptr_clear_mask <= ret_irq ? irq_onehot : '0;
        end
    end

    // Loop setup decode.
    logic is_cnt_loop;
    logic is_cond_loop;
    logic is_loop;
    pc_t end_addr;
    cnt_t load_count;
    loop_entry_s next_entry;

    assign is_cnt_loop = instr_valid && ((instr.kind == KIND_LOOP_IMM) || (instr.kind == KIND_LOOP_UREG));
    assign is_cond_loop = instr_valid && (instr.kind == KIND_LOOP_COND);
    assign is_loop = is_cnt_loop || is_cond_loop;
    // Absolute end address or a wrapping two's-complement offset from the PC.
    assign end_addr = instr.addr_relative ? pc_t'(pc + instr.addr) : instr.addr;
    assign load_count = (instr.kind == KIND_LOOP_IMM) ? instr.imm16 : ureg_data[15:0];
    assign next_entry.end_addr = end_addr;
    assign next_entry.term = is_cnt_loop ? `TERM_LCE : instr.cond;
    assign next_entry.f_active = instr.loop_f_mode;

    // Stack pushes, one-cycle pulses with registered data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_push <= 1'b0;
            pc_push_data <= '0;
            loop_push <= 1'b0;
            loop_push_data <= '0;
            count_push <= 1'b0;
            count_push_data <= `COUNT_RESET;
        end else begin
            pc_push <= is_loop;
            pc_push_data <= pc_t'(pc + `LOOP_START_STEP);
            loop_push <= is_loop;
            loop_push_data <= next_entry;
            count_push <= is_cnt_loop;
            count_push_data <= load_count;
        end
    end

    // Decrement requests from the sequencer, filtered by the reentry guard.
    logic dec_ok;
    logic set_suppress;

    assign set_suppress = ret_go && ret_lr_bit;
    assign dec_ok = loop_dec_tick && !suppress_dec && !lce;

    // Current loop count and the one-shot reentry guard; a new set wins over consume.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            current_loop_count <= `COUNT_RESET;
            suppress_dec <= 1'b0;
        end else begin
            if (is_cnt_loop) begin
                current_loop_count <= load_count;
            end else if (dec_ok) begin
                current_loop_count <= current_loop_count - 16'h0001;
            end
            if (set_suppress) begin
                suppress_dec <= 1'b1;
            end else if (loop_dec_tick || is_loop) begin
                suppress_dec <= 1'b0;
            end
        end
    end

    // Active loop and its termination code.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            loop_active <= 1'b0;
            active_term <= `TERM_FOREVER;
        end else begin
            if (is_loop) begin
                loop_active <= 1'b1;
                active_term <= next_entry.term;
            end else if (loop_exit) begin
                loop_active <= 1'b0;
            end
        end
    end

    // Termination test of the active loop in each element.
    logic term_x;
    logic term_y;
    logic term_forever;
    logic term_hit;

    cond_eval u_term_x (
        .code(active_term),
        .status(status_x),
        .flags(flag_sync),
        .lce(lce),
        .result(term_x)
    );

    cond_eval u_term_y (
        .code(active_term),
        .status(status_y),
        .flags(flag_sync),
        .lce(lce),
        .result(term_y)
    );

    // Forever never ends; dual mode needs both elements to agree.
    assign term_forever = (active_term == `TERM_FOREVER);
    assign term_hit = dual_element_mode ? (term_x && term_y) : term_x;
    assign loop_done = loop_active && !term_forever && term_hit;

endmodule

/* testbench/retloop_props.sv */
`timescale 1ns/10ps
// Watches the decoder pins and ties each output pulse but the compute ones to the instruction taken one edge earlier.
module retloop_props
    import retloop_pkg::*;
#(
    parameter int IRQ_W = 32,
    parameter int IDX_W = 5
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic instr_valid,
    input instr_s instr,
    input pc_t pc,
    input wire logic [31:0] ureg_data,
    input wire logic [IDX_W-1:0] irq_index,
    input wire logic ret_take,
    input wire logic ret_interrupt,
    input wire logic delayed_branch_option,
    input wire logic loop_reentry_option,
    input wire logic compute_y,
    input wire logic compute_y_complement,
    input wire logic pc_push,
    input pc_t pc_push_data,
    input wire logic loop_push,
    input loop_entry_s loop_push_data,
    input wire logic count_push,
    input cnt_t count_push_data,
    input wire logic [IRQ_W-1:0] latch_clear_mask,
    input wire logic [IRQ_W-1:0] mask_ptr_clear_mask
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A return pulse always has a return instruction behind it.
    ret_cause_a: assert property (ret_take |-> $past(instr_valid) && $past(instr.kind) == KIND_RET)
        else $error("return taken without a return instruction");
    uncond_ret_a: assert property (instr_valid && instr.kind == KIND_RET && instr.cond == 5'h1F |=> ret_take)
        else $error("unconditional return not taken");
    ret_opts_a: assert property (instr_valid && instr.kind == KIND_RET && instr.cond == 5'h1F |=>
        ret_interrupt == $past(instr.ret_field[2]) && loop_reentry_option == ($past(instr.ret_field) == 3'h1
        || $past(instr.ret_field) == 3'h3)) else $error("return kind or reentry option wrong");
    db_opt_a: assert property (ret_take |-> delayed_branch_option == $past(instr.ret_field[1]))
        else $error("delay option wrong");
    y_cpl_a: assert property (compute_y_complement == compute_y)
        else $error("second element not on complementary registers");
    irq_clear_a: assert property (ret_interrupt |-> latch_clear_mask == (IRQ_W'(1) << $past(irq_index))
        && mask_ptr_clear_mask == latch_clear_mask) else $error("serviced bit not cleared");
    loop_start_a: assert property (instr_valid && instr.kind inside {KIND_LOOP_IMM, KIND_LOOP_UREG, KIND_LOOP_COND}
        |=> pc_push && loop_push && pc_push_data == $past(pc) + 24'h000001)
        else $error("loop start not pushed");
    count_term_a: assert property (instr_valid && instr.kind == KIND_LOOP_IMM |=> count_push
        && count_push_data == $past(instr.imm16) && loop_push_data.term == 5'h0F) else $error("counter loop push wrong");
    ureg_cnt_a: assert property (instr_valid && instr.kind == KIND_LOOP_UREG |=>
        count_push_data == cnt_t'($past(ureg_data))) else $error("register count wrong");
    cond_term_a: assert property (instr_valid && instr.kind == KIND_LOOP_COND |=> !count_push
        && loop_push_data.term == $past(instr.cond)) else $error("conditional loop push wrong");
    end_addr_a: assert property (loop_push |-> loop_push_data.end_addr == ($past(instr.addr_relative) ?
        $past(pc) + $past(instr.addr) : $past(instr.addr))) else $error("loop end address wrong");
    f_mode_a: assert property (loop_push |-> loop_push_data.f_active == $past(instr.loop_f_mode))
        else $error("loop activation style wrong");
endmodule

bind retloop_decode retloop_props #(.IRQ_W(IRQ_W), .IDX_W(IDX_W)) i_retloop_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .pc(pc), .ureg_data(ureg_data),
    .irq_index(irq_index), .ret_take(ret_take), .ret_interrupt(ret_interrupt),
    .delayed_branch_option(delayed_branch_option), .loop_reentry_option(loop_reentry_option),
    .compute_y(compute_y), .compute_y_complement(compute_y_complement), .pc_push(pc_push),
    .pc_push_data(pc_push_data), .loop_push(loop_push), .loop_push_data(loop_push_data),
    .count_push(count_push), .count_push_data(count_push_data), .latch_clear_mask(latch_clear_mask),
    .mask_ptr_clear_mask(mask_ptr_clear_mask));

/* testbench/retloop_decode_tb.sv */
`timescale 1ns/10ps
// Drives the decoder through register, return and loop sequences and checks every pulse but loop_push.
module retloop_decode_tb
    import retloop_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, ureg_data = 32'h0, reg_rdata, d;
    logic reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0, loop_dec_tick = 1'b0, loop_exit = 1'b0;
    instr_s instr = '0, i;
    pe_status_s status_x = '0, status_y = '0;
    logic [3:0] flag_in = 4'h0;
    pc_t pc = 24'h000000, pc_push_data;
    logic [4:0] irq_index = 5'h00, c;
    logic ret_take, ret_interrupt, delayed_branch_option, loop_reentry_option, compute_x, compute_y;
    logic compute_y_complement, pc_push, loop_push, count_push, loop_active, loop_done, ex, ey, el, m, tx, ty;
    loop_entry_s loop_push_data;
    cnt_t count_push_data, current_loop_count;
    logic [31:0] latch_clear_mask, mask_ptr_clear_mask;
    logic [4:0] codes [3] = '{5'h00, 5'h10, 5'h1F};
    int mismatches = 0, num_checks = 0;

    retloop_decode i_retloop_decode (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .instr_valid(instr_valid), .instr(instr), .status_x(status_x), .status_y(status_y), .flag_in(flag_in),
        .pc(pc), .ureg_data(ureg_data), .irq_index(irq_index), .loop_dec_tick(loop_dec_tick),
        .loop_exit(loop_exit), .ret_take(ret_take), .ret_interrupt(ret_interrupt),
        .delayed_branch_option(delayed_branch_option), .loop_reentry_option(loop_reentry_option),
        .compute_x(compute_x), .compute_y(compute_y), .compute_y_complement(compute_y_complement),
        .pc_push(pc_push), .pc_push_data(pc_push_data), .loop_push(loop_push), .loop_push_data(loop_push_data),
        .count_push(count_push), .count_push_data(count_push_data), .latch_clear_mask(latch_clear_mask),
        .mask_ptr_clear_mask(mask_ptr_clear_mask), .current_loop_count(current_loop_count),
        .loop_active(loop_active), .loop_done(loop_done));

    // Clock of 100 ns period.
    always #50 clk_sys = ~clk_sys;

    // Compares one observed value with its expectation.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read; data are taken in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Presents one instruction with the equal flag of each element; returns in the answer cycle.
    task automatic issue(input instr_s n, input logic sx, input logic sy);
        @(posedge clk_sys);
        instr <= n;
        status_x.eq <= sx;
        status_y.eq <= sy;
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
    endtask

    // One decrement request from the sequencer.
    task automatic tick();
        @(posedge clk_sys);
        loop_dec_tick <= 1'b1;
        @(posedge clk_sys);
        loop_dec_tick <= 1'b0;
        #1;
    endtask

    // Builds an instruction word with compute on and all other fields cleared.
    function automatic instr_s mk(input instr_kind_e k, input logic [2:0] r, input logic [4:0] cc, input logic e);
        instr_s n;
        n = '0;
        n.kind = k;
        n.ret_field = r;
        n.cond = cc;
        n.else_compute = e;
        n.has_compute = 1'b1;
        return n;
    endfunction

    // Watchdog well beyond the expected run of about 230 cycles.
    initial begin
        #2000000;
        mismatches++;
        close_out();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(4'h0, d);
        chk(d, 32'h0);
        wr(4'h0, 32'h1);
        rd(4'h0, d);
        chk(d, 32'h1);
        wr(4'h8, 32'h1);
        rd(4'h8, d);
        chk(d, 32'h0);
        $display("registers test done");
        // Every return field value, unconditional, with a plain compute.
        for (int n = 0; n < 8; n++) begin
            @(posedge clk_sys);
            irq_index <= 5'(3 * n);
            issue(mk(KIND_RET, 3'(n), 5'h1F, 1'b0), 1'b0, 1'b0);
            chk(ret_take, 1'b1);
            chk(compute_x, 1'b1);
            chk(ret_interrupt, n[2]);
            chk(loop_reentry_option, n[0] & ~n[2]);
            chk(delayed_branch_option, n[1]);
            chk(latch_clear_mask, n[2] ? 32'h1 << (3 * n) : 32'h0);
            chk(mask_ptr_clear_mask, n[2] ? 32'h1 << (3 * n) : 32'h0);
        end
        // Conditional return on equal in both modes, with and without else.
        for (int n = 0; n < 16; n++) begin
            {m, el, ey, ex} = 4'(n);
            wr(4'h0, {31'h0, m});
            issue(mk(KIND_RET, 3'h0, 5'h00, el), ex, ey);
            chk(ret_take, m ? ex & ey : ex);
            chk(compute_x, ex ^ el);
            chk(compute_y, m & (ey ^ el));
            chk(compute_y_complement, m & (ey ^ el));
        end
        $display("returns test done");
        wr(4'h0, 32'h0);
        @(posedge clk_sys);
        pc <= 24'h000100;
        i = mk(KIND_LOOP_IMM, 3'h0, 5'h00, 1'b0);
        i.imm16 = 16'h0003;
        i.addr = 24'h00ABCD;
        i.loop_f_mode = 1'b1;
        issue(i, 1'b0, 1'b0);
        chk(pc_push, 1'b1);
        chk(pc_push_data, 24'h000101);
        chk(loop_push_data.end_addr, 24'h00ABCD);
        chk(loop_push_data.term, 5'h0F);
        chk(loop_push_data.f_active, 1'b1);
        chk(count_push_data, 16'h0003);
        chk(current_loop_count, 16'h0003);
        rd(4'h4, d);
        chk(d, 32'h00010003);
        issue(mk(KIND_RET, 3'h1, 5'h1F, 1'b0), 1'b0, 1'b0);
        tick();
        chk(current_loop_count, 16'h0003);
        tick();
        chk(current_loop_count, 16'h0002);
        @(posedge clk_sys);
        pc <= 24'hFFFFFE;
        ureg_data <= 32'hABCD0002;
        i = mk(KIND_LOOP_UREG, 3'h0, 5'h00, 1'b0);
        i.addr_relative = 1'b1;
        i.addr = 24'h000005;
        issue(i, 1'b0, 1'b0);
        chk(loop_push_data.end_addr, 24'h000003);
        chk(loop_push_data.f_active, 1'b0);
        chk(count_push_data, 16'h0002);
        chk(loop_done, 1'b0);
        tick();
        tick();
        chk(current_loop_count, 16'h0000);
        chk(loop_done, 1'b1);
        tick();
        chk(current_loop_count, 16'h0000);
        $display("counter loops test done");
        // Conditional loops: equal, not equal and forever, every flag pair, both modes.
        for (int n = 0; n < 24; n++) begin
            {ey, ex, m} = 3'(n % 8);
            c = codes[n / 8];
            wr(4'h0, {31'h0, m});
            issue(mk(KIND_LOOP_COND, 3'h0, c, 1'b0), ex, ey);
            tx = c[4] ? ~ex : ex;
            ty = c[4] ? ~ey : ey;
            chk(count_push, 1'b0);
            chk(loop_push_data.term, c);
            chk(loop_done, (c != 5'h1F) & (m ? tx & ty : tx));
        end
        @(posedge clk_sys);
        loop_exit <= 1'b1;
        @(posedge clk_sys);
        loop_exit <= 1'b0;
        #1 chk(loop_active, 1'b0);
        $display("conditional loops test done");
        close_out();
    end
endmodule
